// ===== bench/cmf_far_model.sv
// Far side of the controller: analog comparators, OTG_REQUEST_PIN pin and status line pull-up
module cmf_far_model (
    input  wire cmf_pkg::cmf_comp_type cond_in,        // Analog conditions chosen by the bench
    input  wire logic                  otg_req_in,     // Bench wish for an OTG_REQUEST_PIN request
    input  wire logic                  stat_o_in,      // Status pin data from the controller
    input  wire logic                  stat_oe_b_in,   // Status pin enable, low drives
    output cmf_pkg::cmf_comp_type      comp_out,       // Comparator levels to the controller
    output logic                       otg_pin_out,    // OTG_REQUEST_PIN request pin level
    output logic                       stat_line_out   // Resolved status line
);
    timeunit 1ns;
    timeprecision 1ps;

    // Comparators follow the analog levels; no glitch filtering here on purpose
    assign comp_out      = cond_in;
    // OTG_REQUEST_PIN pin stays asserted for as long as the bench asks, so a restart by OTG_REQUEST_PIN can be seen
    assign otg_pin_out   = otg_req_in;
    // Open-drain line: pulled up whenever the controller releases it
    assign stat_line_out = stat_oe_b_in ? 1'b1 : stat_o_in;
endmodule : cmf_far_model

// ===== bench/testbench.sv
// Self-checking bench: register calls with expected values from the mode rules
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   ref_clk;      // 50 MHz clock
    logic                   rst_b;        // Reset, active low
    logic [3:0]             addr;         // Register address
    logic [7:0]             wdata;        // Write data
    logic                   wr;           // Write strobe
    logic                   rd;           // Read strobe
    logic [7:0]             rdata;        // Read data
    logic                   otg_req;      // OTG_REQUEST_PIN wish
    logic                   otg_pin;      // OTG_REQUEST_PIN pin
    cmf_pkg::cmf_comp_type  cond;         // Analog conditions
    cmf_pkg::cmf_comp_type  comp;         // Comparator levels
    cmf_pkg::cmf_power_type power;        // Power-stage enables
    logic                   stat_o;       // Status data
    logic                   stat_oe_b;    // Status enable, low drives
    logic                   stat_line;    // Resolved status line
    logic                   irq;          // Interrupt
    int                     errors;       // Mismatch count
    int                     comparisons;  // Comparison count
    int                     por_cnt;      // Reset request pulses seen
    int                     low_cnt;      // Current low run of the status line
    int                     last_width;   // Length of the last low run
    logic [7:0]             rv;           // Last read value
    logic                   ce;           // Clock enable
    logic                   por_req;      // Reset request pulse
    logic                   long_mode;    // 32-minute mode flag

    // Clock: toggled every half period
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    cmf_ctrl dut (
        .REF_CLK_IN         (ref_clk),
        .RST_B_IN           (rst_b),
        .CE_IN              (ce),
        .ADDR_IN            (addr),
        .WDATA_IN           (wdata),
        .WR_IN              (wr),
        .RD_IN              (rd),
        .RDATA_OUT          (rdata),
        .OTG_REQUEST_PIN_IN (otg_pin),
        .COMP_IN            (comp),
        .POWER_OUT          (power),
        .STAT_O_OUT         (stat_o),
        .STAT_OE_B_OUT      (stat_oe_b),
        .IRQ_OUT            (irq),
        .LONG_MODE_OUT      (long_mode),
        .POR_REQ_OUT        (por_req)
    );

    cmf_far_model far (
        .cond_in       (cond),
        .otg_req_in    (otg_req),
        .stat_o_in     (stat_o),
        .stat_oe_b_in  (stat_oe_b),
        .comp_out      (comp),
        .otg_pin_out   (otg_pin),
        .stat_line_out (stat_line)
    );

    // Monitor: counts reset requests and measures each low pulse on the status line
    always @(posedge ref_clk) begin
        if (por_req === 1'b1) por_cnt <= por_cnt + 1;
        if (stat_line === 1'b0) low_cnt <= low_cnt + 1;
        else if (low_cnt != 0) begin
            last_width <= low_cnt;
            low_cnt    <= 0;
        end
    end

    task automatic close_out;
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out

    // One compare for every kind of result; narrower values are zero-extended
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        rd_reg(a, rv);
        chk({24'h0, rv}, {24'h0, exp}, what);
    endtask : rd_chk

    // Polls the mode field under a bound; a miss ends the run
    task automatic wait_state(input logic [2:0] st);
        int n;
        n = 0;
        rd_reg(cmf_pkg::ADDR_STATE, rv);
        while (rv[2:0] !== st && n < 40) begin
            rd_reg(cmf_pkg::ADDR_STATE, rv);
            n++;
        end
        chk({29'h0, rv[2:0]}, {29'h0, st}, "state");
        if (rv[2:0] !== st) close_out();
    endtask : wait_state

    task automatic not_state(input logic [2:0] st);
        rd_reg(cmf_pkg::ADDR_STATE, rv);
        chk({31'h0, rv[2:0] === st}, 32'h0, "mode held");
    endtask : not_state

    // Power enables change in the same cycle as the mode; checked two cycles later
    task automatic chk_power(input logic [4:0] exp);
        repeat (2) @(posedge ref_clk);
        #1 chk({27'h0, power}, {27'h0, exp}, "power");
    endtask : chk_power

    // Main sequence
    initial begin
        rst_b = 1'b0; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0; otg_req = 1'b0;
        cond = '0; cond.bus_below_uvlo = 1'b1; cond.bat_below_short = 1'b1;
        ce = 1'b1;
        errors = 0; comparisons = 0; por_cnt = 0; low_cnt = 0; last_width = 0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        wait_state(cmf_pkg::ST_PWR_DOWN);
        chk_power(5'h00);
        rd_chk(cmf_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
        rd_chk(cmf_pkg::ADDR_MASK, 8'h00, "mask reset");
        rd_chk(cmf_pkg::ADDR_FAULT, 8'h00, "fault reset");
        rd_chk(4'hF, 8'h00, "unmapped");
        // Leaving power-down asks for a reset once
        cond.bus_below_uvlo <= 1'b0;
        cond.bat_below_short <= 1'b0;
        wait_state(cmf_pkg::ST_PWM_CHG);
        chk_power(5'h12);
        chk(por_cnt, 1, "reset requests");
        // Clock enable low freezes the synchronisers and the mode alike
        ce <= 1'b0;
        cond.bat_below_short <= 1'b1;
        repeat (8) @(posedge ref_clk);
        ce <= 1'b1;
        not_state(cmf_pkg::ST_SHORT);
        wait_state(cmf_pkg::ST_SHORT);
        chk_power(5'h06);
        cond.bat_below_short <= 1'b0;
        // Three causes of charge configure in turn: disable bit, weak bus, charge fault
        for (int i = 0; i < 3; i++) begin
            if (i == 0) wr_reg(cmf_pkg::ADDR_CTRL, 8'h04);
            if (i == 1) cond.bus_below_min <= 1'b1;
            if (i == 2) cond.chg_fault <= 1'b1;
            wait_state(cmf_pkg::ST_CHG_CFG);
            chk_power(5'h02);
            wr_reg(cmf_pkg::ADDR_CTRL, 8'h00);
            cond.bus_below_min <= 1'b0;
            cond.chg_fault <= 1'b0;
            repeat (8) @(posedge ref_clk);
            wr_reg(cmf_pkg::ADDR_FAULT, 8'h0F);
            wait_state(cmf_pkg::ST_PWM_CHG);
        end
        wr_reg(cmf_pkg::ADDR_CTRL, 8'h02);
        wait_state(cmf_pkg::ST_HIZ);
        chk_power(5'h00);
        otg_req <= 1'b1;
        repeat (8) @(posedge ref_clk);
        not_state(cmf_pkg::ST_HIZ);
        otg_req <= 1'b0;
        wr_reg(cmf_pkg::ADDR_CTRL, 8'h00);
        // Bus overvoltage while boosting
        wr_reg(cmf_pkg::ADDR_MASK, 8'h0F);
        wr_reg(cmf_pkg::ADDR_CTRL, 8'h01);
        wait_state(cmf_pkg::ST_BOOST);
        chk_power(5'h0A);
        cond.bus_ov <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rd_chk(cmf_pkg::ADDR_FAULT, 8'h01, "bus ov flag");
        rd_chk(cmf_pkg::ADDR_CTRL, 8'h00, "boost bit");
        chk({31'h0, irq}, 32'h1, "irq raised");
        chk({31'h0, power.boost_en}, 32'h0, "boost off");
        cond.bus_ov <= 1'b0;
        repeat (cmf_pkg::PULSE_CYC + 50) @(posedge ref_clk);
        chk(last_width, cmf_pkg::PULSE_CYC, "pulse width");
        not_state(cmf_pkg::ST_BOOST);
        wr_reg(cmf_pkg::ADDR_FAULT, 8'h01);
        repeat (2) @(posedge ref_clk);
        #1 chk({31'h0, irq}, 32'h0, "irq cleared");
        rd_chk(cmf_pkg::ADDR_FAULT, 8'h00, "fault cleared");
        wr_reg(cmf_pkg::ADDR_CTRL, 8'h01);
        wait_state(cmf_pkg::ST_BOOST);
        // Short overload: limiting only, no fault yet
        cond.overload <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1 chk({31'h0, power.pass_sw_limit}, 32'h1, "limit");
        repeat (200) @(posedge ref_clk);
        rd_chk(cmf_pkg::ADDR_FAULT, 8'h00, "early overload");
        cond.overload <= 1'b0;
        // Battery too low while boosting, then OTG_REQUEST_PIN keeps the request
        cond.bat_below_min <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rd_chk(cmf_pkg::ADDR_FAULT, 8'h04, "battery flag");
        rd_chk(cmf_pkg::ADDR_CTRL, 8'h00, "boost bit");
        wr_reg(cmf_pkg::ADDR_MASK, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1 chk({31'h0, irq}, 32'h0, "irq masked");
        otg_req <= 1'b1;
        cond.bat_below_min <= 1'b0;
        wait_state(cmf_pkg::ST_BOOST);
        chk({31'h0, long_mode}, 32'h0, "long mode");
        close_out();
    end
endmodule : testbench

// ===== verilog/cmf_ctrl.sv
// Function
// R1: Bus overvoltage in boost: stop, clear, flag, pulse
// R2: Boost restarts only by rewrite or OTG_REQUEST_PIN
// R3: Overload limits current; fault after 30 ms
// R4: Overload fault stops boost until cleared
// R5: Battery out of range in boost: stop, flag
// R6: Battery recovery needs rewrite or OTG_REQUEST_PIN
// R7: Status pin released; boost fault gives 128 us pulse
// R8: High-impedance bit set, OTG_REQUEST_PIN inactive: high-impedance
// R9: Coarse 32 s timer while battery low in high-impedance
// R10: Coarse expiry enters 32-minute mode, timer stops
// R11: 32-minute mode: bus below lockout forces high-impedance
// R12: Charge configure when bus low, disabled, faulted
// R13: Battery below short threshold selects short state
// R14: Battery above short threshold selects PWM charge
// R15: Latched faults clear only by reset or host
// R16: Power-down when bus and battery low; reset after
// R17: Comparator inputs synchronised before use
module cmf_ctrl (
    input  wire logic                  REF_CLK_IN,       // 50 MHz clock
    input  wire logic                  RST_B_IN,         // Async reset, active low
    input  wire logic                  CE_IN,            // Clock enable
    input  wire logic [3:0]            ADDR_IN,          // Register address
    input  wire logic [7:0]            WDATA_IN,         // Write data
    input  wire logic                  WR_IN,            // Write strobe
    input  wire logic                  RD_IN,            // Read strobe
    output logic      [7:0]            RDATA_OUT,        // Read data, cycle after strobe
    input  wire logic                  OTG_REQUEST_PIN_IN, // OTG_REQUEST_PIN pin, asynchronous
    input  wire cmf_pkg::cmf_comp_type COMP_IN,          // Analog comparators
    output cmf_pkg::cmf_power_type     POWER_OUT,        // Power-stage enables
    output logic                       STAT_O_OUT,       // Status pin data (always low)
    output logic                       STAT_OE_B_OUT,    // Status pin enable, low drives
    output logic                       IRQ_OUT,          // Interrupt, level
    output logic                       LONG_MODE_OUT,    // 32-minute mode flag
    output logic                       POR_REQ_OUT       // Power-on reset request pulse
);
    // Synchronised inputs
    cmf_pkg::cmf_comp_type comp;      // Comparators in clock domain
    logic                  otg_request_pin;       // OTG_REQUEST_PIN request in clock domain

    // Register state
    logic [7:0]                    ctrl_q, ctrl_d;     // Control register
    logic [cmf_pkg::FLT_W-1:0]     fault_q, fault_d;   // Sticky fault status
    logic [cmf_pkg::FLT_W-1:0]     mask_q, mask_d;     // Interrupt mask
    logic [7:0]                    rdata_d;            // Next read data

    // Mode state
    cmf_pkg::cmf_state_type        state_q, state_d;   // Operating mode
    logic                          long_q, long_d;     // 32-minute mode
    logic                          por_d;              // Reset request on power-down exit
    cmf_pkg::cmf_power_type        power_d;            // Next power enables
    logic                          irq_d;              // Next interrupt
    logic [cmf_pkg::SYNC_LAT-1:0]  warm_q, warm_d;     // Synchroniser fill after reset
    logic                          sync_ok;            // Comparator levels are real

    // Pulse state
    logic [15:0]                   pulse_q, pulse_d;   // Pulse countdown
    logic                          stat_oe_b_d;        // Next status enable

    // Events
    logic [cmf_pkg::FLT_W-1:0]     evt;                // Fault events this cycle
    logic                          ovld_done;          // Overload qualified
    logic                          supv_done;          // Coarse timer expired
    logic                          supv_run;           // Coarse timer enable
    logic                          boost_req;          // Boost requested
    logic                          hiz_req;            // High-impedance requested

    // Comparator synchroniser
    cmf_sync #(.W($bits(cmf_pkg::cmf_comp_type)+1)) u_sync (   // R17
        .clk_in   (REF_CLK_IN),
        .rst_b_in (RST_B_IN),
        .ce_in    (CE_IN),
        .d_in     ({COMP_IN, OTG_REQUEST_PIN_IN}),
        .q_out    ({comp, otg_request_pin})
    );

    // Overload qualification, only counted in boost
    cmf_timer #(.CW(36), .LIMIT(36'(cmf_pkg::OVLD_CYC))) u_ovld (   // R3
        .clk_in   (REF_CLK_IN),
        .rst_b_in (RST_B_IN),
        .ce_in    (CE_IN),
        .run_in   (comp.overload && state_q == cmf_pkg::ST_BOOST),
        .done_out (ovld_done)
    );

    // Coarse supervision: high-impedance, battery low, not yet long mode
    assign supv_run = (state_q == cmf_pkg::ST_HIZ) && comp.bat_below_low && !long_q;  // R9 R10
    cmf_timer #(.CW(36), .LIMIT(36'(cmf_pkg::SUPV_CYC))) u_supv (   // R9
        .clk_in   (REF_CLK_IN),
        .rst_b_in (RST_B_IN),
        .ce_in    (CE_IN),
        .run_in   (supv_run),
        .done_out (supv_done)
    );

    // Requests from register and pin; OTG_REQUEST_PIN keeps boost requested after faults
    assign boost_req = ctrl_q[cmf_pkg::CTRL_BOOST] || otg_request_pin;    // R2 R6
    assign sync_ok   = warm_q[cmf_pkg::SYNC_LAT-1];           // R17
    assign hiz_req   = ctrl_q[cmf_pkg::CTRL_HIZ] && !otg_request_pin;     // R8

    // Boost and charge fault events
    always_comb begin
        evt = '0;
        if (state_q == cmf_pkg::ST_BOOST) begin
            evt[cmf_pkg::FLT_BUS_OV] = comp.bus_ov;                            // R1
            evt[cmf_pkg::FLT_OVLD]   = ovld_done;                              // R3
            evt[cmf_pkg::FLT_BAT]    = comp.bat_over || comp.bat_below_min;    // R5
        end
        if (state_q == cmf_pkg::ST_SHORT || state_q == cmf_pkg::ST_PWM_CHG) begin
            evt[cmf_pkg::FLT_CHG] = comp.chg_fault;
        end
    end

    // Register file next state
    always_comb begin
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        fault_d = fault_q;
        rdata_d = 8'h00;
        if (WR_IN) begin
            unique case (ADDR_IN)
                cmf_pkg::ADDR_CTRL:  ctrl_d  = WDATA_IN;
                cmf_pkg::ADDR_MASK:  mask_d  = WDATA_IN[cmf_pkg::FLT_W-1:0];
                // Write one to clear; only host or reset clears faults
                cmf_pkg::ADDR_FAULT: fault_d = fault_q & ~WDATA_IN[cmf_pkg::FLT_W-1:0];   // R15
                default: ;
            endcase
        end
        // Any boost fault drops the request bit, drop beats write
        if (|evt[cmf_pkg::FLT_BAT:cmf_pkg::FLT_BUS_OV]) begin
            ctrl_d[cmf_pkg::CTRL_BOOST] = 1'b0;    // R1 R4 R5
        end
        fault_d = fault_d | evt;    // Set wins over clear
        if (RD_IN) begin
            unique case (ADDR_IN)
                cmf_pkg::ADDR_CTRL:  rdata_d = ctrl_q;
                cmf_pkg::ADDR_FAULT: rdata_d = 8'(fault_q);
                cmf_pkg::ADDR_MASK:  rdata_d = 8'(mask_q);
                cmf_pkg::ADDR_STATE: rdata_d = {4'h0, long_q, state_q};
                default:             rdata_d = 8'h00;
            endcase
        end
    end

    // Mode selection and power enables
    always_comb begin
        state_d = state_q;
        long_d  = long_q | supv_done;     // R10
        por_d   = 1'b0;
        power_d = '0;
        warm_d  = {warm_q[cmf_pkg::SYNC_LAT-2:0], 1'b1};
        // Synchronisers read zero after reset; without this hold a false exit
        // from power-down would raise a spurious reset request
        if (!sync_ok || (comp.bus_below_uvlo && comp.bat_below_short)) begin
            state_d = cmf_pkg::ST_PWR_DOWN;                                         // R16
        end else if (hiz_req || (long_q && comp.bus_below_uvlo)) begin
            state_d = cmf_pkg::ST_HIZ;                                              // R8 R11
        end else if (boost_req && !ctrl_q[cmf_pkg::CTRL_HIZ] && !fault_q[cmf_pkg::FLT_OVLD]
                     && !comp.bat_below_min && !(|evt)) begin
            state_d = cmf_pkg::ST_BOOST;                                            // R4
        end else if (comp.bus_below_uvlo) begin
            state_d = cmf_pkg::ST_HIZ;
        end else if (comp.bus_below_min || ctrl_q[cmf_pkg::CTRL_CHG_DIS] || fault_q[cmf_pkg::FLT_CHG]
                     || evt[cmf_pkg::FLT_CHG] || boost_req) begin
            state_d = cmf_pkg::ST_CHG_CFG;                                          // R12
        end else if (comp.bat_below_short) begin
            state_d = cmf_pkg::ST_SHORT;                                            // R13
        end else begin
            state_d = cmf_pkg::ST_PWM_CHG;                                          // R14
        end
        // Leaving power-down restarts the chip
        if (state_q == cmf_pkg::ST_PWR_DOWN && state_d != cmf_pkg::ST_PWR_DOWN) begin
            por_d = 1'b1;                                                           // R16
        end
        unique case (state_d)
            cmf_pkg::ST_SHORT: begin
                power_d.short_src_en = 1'b1;                                        // R13
                power_d.pass_sw_en   = 1'b1;
            end
            cmf_pkg::ST_PWM_CHG: begin
                power_d.buck_en    = 1'b1;                                          // R14
                power_d.pass_sw_en = 1'b1;
            end
            cmf_pkg::ST_BOOST: begin
                power_d.boost_en      = 1'b1;
                power_d.pass_sw_en    = 1'b1;
                power_d.pass_sw_limit = comp.overload;                              // R3
            end
            cmf_pkg::ST_CHG_CFG: power_d.pass_sw_en = 1'b1;
            default: ;      // Power-down and high-impedance: all off
        endcase
    end

    // Status pin pulse: released unless a boost fault just occurred
    always_comb begin
        pulse_d = pulse_q;
        if (|evt[cmf_pkg::FLT_BAT:cmf_pkg::FLT_BUS_OV]) begin
            pulse_d = 16'(cmf_pkg::PULSE_CYC);                                      // R7
        end else if (pulse_q != 16'h0000) begin
            pulse_d = pulse_q - 16'h0001;
        end
        stat_oe_b_d = (pulse_d == 16'h0000);                                        // R7
        irq_d       = |(fault_d & mask_d);
    end

    // Register all state
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ctrl_q        <= cmf_pkg::CTRL_RST;
            fault_q       <= '0;
            mask_q        <= cmf_pkg::MASK_RST[cmf_pkg::FLT_W-1:0];
            state_q       <= cmf_pkg::ST_PWR_DOWN;
            long_q        <= 1'b0;
            warm_q        <= '0;
            pulse_q       <= 16'h0000;
            RDATA_OUT     <= 8'h00;
            POWER_OUT     <= '0;
            STAT_O_OUT    <= 1'b0;
            STAT_OE_B_OUT <= 1'b1;
            IRQ_OUT       <= 1'b0;
            LONG_MODE_OUT <= 1'b0;
            POR_REQ_OUT   <= 1'b0;
        end else if (CE_IN) begin
            ctrl_q        <= ctrl_d;
            fault_q       <= fault_d;
            mask_q        <= mask_d;
            state_q       <= state_d;
            long_q        <= long_d;
            warm_q        <= warm_d;
            pulse_q       <= pulse_d;
            RDATA_OUT     <= rdata_d;
            POWER_OUT     <= power_d;
            STAT_O_OUT    <= 1'b0;
            STAT_OE_B_OUT <= stat_oe_b_d;
            IRQ_OUT       <= irq_d;
            LONG_MODE_OUT <= long_d;
            POR_REQ_OUT   <= por_d;
        end
    end

    // Checks
    bus_ov_clear_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)   // R1
        CE_IN && state_q == cmf_pkg::ST_BOOST && comp.bus_ov |=> !ctrl_q[cmf_pkg::CTRL_BOOST]
        && fault_q[cmf_pkg::FLT_BUS_OV]) else $error("bus overvoltage not handled");
    ovld_block_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)     // R4
        fault_q[cmf_pkg::FLT_OVLD] |-> state_q != cmf_pkg::ST_BOOST) else $error("boost with overload fault");
    bat_fault_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)      // R5
        CE_IN && state_q == cmf_pkg::ST_BOOST && comp.bat_below_min |=> fault_q[cmf_pkg::FLT_BAT])
        else $error("battery fault not flagged");
    stat_pulse_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)     // R7
        CE_IN && (|evt[cmf_pkg::FLT_BAT:cmf_pkg::FLT_BUS_OV]) |=> !STAT_OE_B_OUT)
        else $error("no status pulse");
    hiz_entry_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)      // R8
        CE_IN && sync_ok && hiz_req && !(comp.bus_below_uvlo && comp.bat_below_short)
        |=> state_q == cmf_pkg::ST_HIZ)
        else $error("high impedance not entered");
    long_stop_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)      // R10
        long_q && $past(long_q) |-> !supv_done) else $error("coarse timer running in long mode");
    fault_hold_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)     // R15
        fault_q[cmf_pkg::FLT_OVLD] && !(WR_IN && ADDR_IN == cmf_pkg::ADDR_FAULT) |=> fault_q[cmf_pkg::FLT_OVLD])
        else $error("fault cleared without host");
    por_exit_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)       // R16
        CE_IN && state_q == cmf_pkg::ST_PWR_DOWN && state_d != cmf_pkg::ST_PWR_DOWN |=> POR_REQ_OUT)
        else $error("no reset on power-down exit");

endmodule : cmf_ctrl

// ===== verilog/cmf_pkg.sv
package cmf_pkg;

    // Clock rate in kHz
    localparam int unsigned CLK_KHZ          = 50000;
    // Overload qualification time in ms
    localparam int unsigned OVLD_MS          = 30;
    // Overload qualification in cycles
    localparam int unsigned OVLD_CYC         = OVLD_MS * CLK_KHZ;
    // Fault pulse width in us
    localparam int unsigned PULSE_US         = 128;
    // Fault pulse width in cycles
    localparam int unsigned PULSE_CYC        = (PULSE_US * CLK_KHZ) / 1000;
    // Coarse supervision time in s
    localparam int unsigned SUPV_S           = 32;
    // Coarse supervision time in cycles (computed in 64 bits)
    localparam longint unsigned SUPV_CYC     = 64'(SUPV_S) * 64'(CLK_KHZ) * 64'd1000;
    // Enabled edges before a pin change shows at the synchroniser output
    localparam int unsigned SYNC_LAT         = 4;

    // Register offsets
    localparam logic [3:0] ADDR_CTRL         = 4'h0;
    localparam logic [3:0] ADDR_FAULT        = 4'h1;
    localparam logic [3:0] ADDR_MASK         = 4'h2;
    localparam logic [3:0] ADDR_STATE        = 4'h3;

    // Control field positions
    localparam int unsigned CTRL_BOOST       = 0;
    localparam int unsigned CTRL_HIZ         = 1;
    localparam int unsigned CTRL_CHG_DIS     = 2;

    // Fault field positions
    localparam int unsigned FLT_BUS_OV       = 0;
    localparam int unsigned FLT_OVLD         = 1;
    localparam int unsigned FLT_BAT          = 2;
    localparam int unsigned FLT_CHG          = 3;
    localparam int unsigned FLT_W            = 4;

    // Reset values
    localparam logic [7:0] CTRL_RST          = 8'h00;
    localparam logic [7:0] MASK_RST          = 8'h00;

    // Comparator inputs from the analog section
    typedef struct packed {
        logic bus_ov;
        logic overload;
        logic bat_over;
        logic bat_below_min;
        logic bat_below_low;
        logic bat_below_short;
        logic bus_below_uvlo;
        logic bus_below_min;
        logic chg_fault;
    } cmf_comp_type;

    // Power-stage enables
    typedef struct packed {
        logic buck_en;
        logic boost_en;
        logic short_src_en;
        logic pass_sw_en;
        logic pass_sw_limit;
    } cmf_power_type;

    // Operating modes
    typedef enum logic [2:0] {
        ST_PWR_DOWN  = 3'b000,
        ST_CHG_CFG   = 3'b001,
        ST_SHORT     = 3'b010,
        ST_PWM_CHG   = 3'b011,
        ST_HIZ       = 3'b100,
        ST_BOOST     = 3'b101
    } cmf_state_type;

endpackage : cmf_pkg

// ===== verilog/cmf_sync.sv
// Three-stage synchroniser; output changes when stages two and three agree
module cmf_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] s1_q;   // Metastability stage, read by s2 only
    logic [W-1:0] s2_q;   // Second stage
    logic [W-1:0] s3_q;   // Third stage
    logic [W-1:0] o_d;    // Next filtered value

    // Filter: accept a bit only once two stages agree
    generate
        for (genvar i = 0; i < W; i++) begin : g_bit
            always_comb begin
                o_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : q_out[i];
            end
        end
    endgenerate

    // Register the chain
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            q_out <= '0;
        end else if (ce_in) begin
            s1_q  <= d_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            q_out <= o_d;
        end
    end
endmodule : cmf_sync

// ===== verilog/cmf_timer.sv
// Saturating qualify timer: done once run has held for LIMIT cycles
module cmf_timer #(
    parameter int unsigned     CW    = 36,
    parameter logic [CW-1:0]   LIMIT = '1
) (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic ce_in,
    input  wire logic run_in,
    output logic      done_out
);
    logic [CW-1:0] cnt_q;   // Elapsed cycles
    logic [CW-1:0] cnt_d;   // Next count
    logic          done_d;  // Next done

    // Count while running, restart when run drops
    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (!run_in) begin
            cnt_d = '0;
        end else if (cnt_q >= LIMIT - 1'b1) begin
            done_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    // Register count and done
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q    <= '0;
            done_out <= 1'b0;
        end else if (ce_in) begin
            cnt_q    <= cnt_d;
            done_out <= done_d;
        end
    end
endmodule : cmf_timer
